// ---- src/posref_pkg.sv ----
/*
  constants, register map and encodings of the position reference front end.
  assumes a single 50 MHz clock shared by every module that uses it.
*/
package posref_pkg;

  // clock rate and the stepping speed figure
  localparam int CLK_HZ = 50_000_000;
  localparam int STEP_RPM = 24;
  // reference units per motor turn at unity gear; stands in for the gear
  localparam int UNITS_PER_REV = 10_000;
  // cycles between two step units at the stepping speed (rounded down)
  localparam int STEP_PERIOD_CYC = CLK_HZ / (STEP_RPM * UNITS_PER_REV / 60);

  ////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] SRC_OFS = 8'h00;
  localparam logic [7:0] STEP_OFS = 8'h04;
  localparam logic [7:0] FORM_OFS = 8'h08;
  localparam logic [7:0] CLRM_OFS = 8'h0C;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] ERR_OFS = 8'h18;

  // reset values
  localparam logic [15:0] SRC_RST = 16'h0000;
  localparam logic [15:0] STEP_RST = 16'h0032;
  localparam logic [15:0] FORM_RST = 16'h0000;
  localparam logic [15:0] CLRM_RST = 16'h0000;

  // step amount limits, +9999 and -9999
  localparam logic signed [15:0] STEP_MAX = 16'sh270F;
  localparam logic signed [15:0] STEP_MIN = -16'sh270F;
  // stepping speed as a signed word
  localparam logic signed [15:0] STEP_SPEED = 16'sh0018;

  // control and status bit positions
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_SERVO_ON_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SERVO_OFF_BIT = 1;
  localparam int STAT_FORM_LSB = 2;

  ////////////////////////////////////////////////////////////////////////
  // position reference source
  typedef enum logic [1:0] {
    SRC_PULSE = 2'b00,
    SRC_STEP = 2'b01,
    SRC_MULTI = 2'b10,
    SRC_COMM = 2'b11
  } src_t;

  // command pulse form
  typedef enum logic [1:0] {
    FORM_PD_POS = 2'b00,
    FORM_PD_NEG = 2'b01,
    FORM_QUAD = 2'b10,
    FORM_CW_CCW = 2'b11
  } form_t;

  // error clear mode
  typedef enum logic [2:0] {
    CLR_FAULT_OFF = 3'b000,
    CLR_FAULT = 3'b001,
    CLR_LEVEL_HI = 3'b010,
    CLR_LEVEL_LO = 3'b011,
    CLR_RISE = 3'b100,
    CLR_FALL = 3'b101
  } clrm_t;

endpackage

// ---- src/ref_if.sv ----
/*
  one reference unit stream: a one-cycle pulse per unit and its direction.
  assumes producer and consumer run on the same clock.
*/
`timescale 1ns/1ps
interface ref_if;
  logic pulse; // one unit this cycle
  logic dir; // 1 = reverse
  modport src (output pulse, output dir);
  modport sink (input pulse, input dir);
endinterface

// ---- src/pulse_decoder.sv ----
/*
  decodes the two command pulse lines into reference units.
  assumes both lines are already synchronised to clk_i.
*/
`timescale 1ns/1ps
module pulse_decoder (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire posref_pkg::form_t form_i,
  input wire logic line_a_i,
  input wire logic line_b_i,
  ref_if.src unit_o
);

  typedef struct packed {
    logic a_q; // previous line a
    logic b_q; // previous line b
    logic pulse;
    logic dir;
  } dec_state_t;

  dec_state_t s_reg;
  dec_state_t s_next;
  logic a_chg;
  logic b_chg;

  ////////////////////////////////////////////////////////////////////////
  // next state per pulse form
  always_comb begin
    s_next = s_reg;
    s_next.a_q = line_a_i;
    s_next.b_q = line_b_i;
    s_next.pulse = 1'b0;
    a_chg = line_a_i != s_reg.a_q;
    b_chg = line_b_i != s_reg.b_q;
    case (form_i)
      posref_pkg::FORM_PD_POS: begin
        // rising edge counts, sign high is forward
        if (line_a_i && !s_reg.a_q) begin
          s_next.pulse = 1'b1;
          s_next.dir = !line_b_i;
        end
      end
      posref_pkg::FORM_PD_NEG: begin
        // falling edge counts, sign low is forward
        if (!line_a_i && s_reg.a_q) begin
          s_next.pulse = 1'b1;
          s_next.dir = line_b_i;
        end
      end
      posref_pkg::FORM_QUAD: begin
        // every single edge is a unit; a double jump is a glitch, dropped
        if (a_chg ^ b_chg) begin
          s_next.pulse = 1'b1;
          // a leading b: new b equals old a
          s_next.dir = line_b_i != s_reg.a_q;
        end
      end
      posref_pkg::FORM_CW_CCW: begin
        // simultaneous rises cancel out, nothing counted
        if (line_a_i && !s_reg.a_q && !(line_b_i && !s_reg.b_q)) begin
          s_next.pulse = 1'b1;
          s_next.dir = 1'b0;
        end else if (line_b_i && !s_reg.b_q && !(line_a_i && !s_reg.a_q)) begin
          s_next.pulse = 1'b1;
          s_next.dir = 1'b1;
        end
      end
      default: s_next.pulse = 1'b0;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign unit_o.pulse = s_reg.pulse;
  assign unit_o.dir = s_reg.dir;

  ////////////////////////////////////////////////////////////////////////
  quad_count_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    form_i == posref_pkg::FORM_QUAD && (line_a_i != s_reg.a_q) && (line_b_i == s_reg.b_q)
    |=> s_reg.pulse && (s_reg.dir == (s_reg.b_q != $past(s_reg.a_q))))
    else $error("quadrature edge not counted");

endmodule

// ---- src/step_gen.sv ----
/*
  stepping source: one move of the step amount per trigger rise while idle.
  assumes trigger is synchronised and enable comes from the same clock.
*/
`timescale 1ns/1ps
module step_gen #(
  parameter int PERIOD_CYC = posref_pkg::STEP_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic trig_i,
  input wire logic signed [15:0] amount_i,
  output logic busy_o,
  ref_if.src unit_o
);

  localparam logic [15:0] TMR_LOAD = 16'(PERIOD_CYC - 1);

  typedef struct packed {
    logic trig_q;
    logic busy;
    logic [13:0] remain; // units still to send
    logic [15:0] tmr;
    logic pulse;
    logic dir;
  } step_state_t;

  step_state_t s_reg;
  step_state_t s_next;
  logic [15:0] mag;

  ////////////////////////////////////////////////////////////////////////
  // move start, unit pacing and end of move
  always_comb begin
    s_next = s_reg;
    s_next.trig_q = trig_i;
    s_next.pulse = 1'b0;
    mag = amount_i[15] ? 16'(-amount_i) : amount_i;
    if (!enable_i) begin
      // source switched away: the move is dropped, not finished later
      s_next.busy = 1'b0;
    end else if (!s_reg.busy) begin
      // trigger rise only counts while idle
      if (trig_i && !s_reg.trig_q && mag != 16'h0000) begin
        s_next.busy = 1'b1;
        s_next.remain = mag[13:0];
        s_next.dir = amount_i[15];
        s_next.tmr = TMR_LOAD;
      end
    end else if (s_reg.tmr == 16'h0000) begin
      s_next.pulse = 1'b1;
      s_next.remain = s_reg.remain - 14'h0001;
      s_next.tmr = TMR_LOAD;
      if (s_reg.remain == 14'h0001) begin
        s_next.busy = 1'b0;
      end
    end else begin
      s_next.tmr = s_reg.tmr - 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign busy_o = s_reg.busy;
  assign unit_o.pulse = s_reg.pulse;
  assign unit_o.dir = s_reg.dir;

  ////////////////////////////////////////////////////////////////////////
  step_load_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    enable_i && !s_reg.busy && trig_i && !s_reg.trig_q && amount_i != 16'sh0000
    |=> s_reg.busy && s_reg.remain == $past(mag[13:0]))
    else $error("step move not started");

  step_ignore_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    enable_i && s_reg.busy && s_reg.tmr != 16'h0000
    |=> s_reg.remain == $past(s_reg.remain))
    else $error("trigger accepted while moving");

  idle_quiet_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !s_reg.busy ##1 !s_reg.busy |-> !s_reg.pulse)
    else $error("step unit while idle");

endmodule

// ---- src/position_reference_frontend.sv ----
/*
  position reference front end: source select, command pulse decode,
  stepping moves and position error clearing, with a small register port.
  assumes pins are asynchronous; fault and feedback come from clk_i logic.
*/
`timescale 1ns/1ps

// Behaviour
// - source select: pulse, step, multi, comm
// - direction select input reverses reference direction
// - signed step amount, -9999..9999, default 50
// - stepping speed is 24 rpm times gear; the code outputs a fixed 24 rpm with no gear factor
// - stepping speed sign from direction select
// - trigger starts one step move
// - no trigger gives zero reference
// - trigger ignored while step move runs
// - four pulse forms by form selector
// - quadrature counts every edge, times four
// - mode 0: servo off, clear on fault
// - mode 1: clear on fault, servo stays
// - modes 2/3: clear while input high/low
// - modes 4/5: clear on rising/falling edge
module position_reference_frontend #(
  parameter int STEP_PERIOD_CYC = posref_pkg::STEP_PERIOD_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  // pins from the motion controller
  input wire logic command_pulse_input_i,
  input wire logic sign_input_i,
  input wire logic step_trigger_i,
  input wire logic position_direction_select_i,
  input wire logic error_clear_input_i,
  // same-clock drive logic
  input wire logic fault_i,
  input wire logic fb_pulse_i,
  input wire logic fb_dir_i,
  // outputs
  output logic ref_pulse_o,
  output logic ref_dir_o,
  output logic signed [15:0] speed_rpm_o,
  output logic step_busy_o,
  output logic servo_off_o,
  output logic signed [31:0] err_count_o
);

  typedef struct packed {
    logic [4:0] sync_m; // first stage, read only by sync_s
    logic [4:0] sync_s; // second stage
    logic clr_q; // previous clear level
    logic [15:0] src;
    logic [15:0] step;
    logic [15:0] form;
    logic [15:0] clrm;
    logic [1:0] act_form; // form in force
    logic load_form; // pending restart load
    logic ref_pulse;
    logic ref_dir;
    logic signed [15:0] speed;
    logic busy;
    logic servo_off;
    logic signed [31:0] err;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;

  ref_if dec_u ();
  ref_if stp_u ();

  logic stp_busy;
  logic a_s, b_s, trig_s, dsel_s, clr_s;
  logic sel_pulse, sel_dir, do_clear;
  logic signed [31:0] delta;
  logic signed [15:0] wval;
  posref_pkg::src_t src_sel;
  posref_pkg::clrm_t clr_mode;

  // synchronised pin levels
  assign a_s = s_reg.sync_s[0];
  assign b_s = s_reg.sync_s[1];
  assign trig_s = s_reg.sync_s[2];
  assign dsel_s = s_reg.sync_s[3];
  assign clr_s = s_reg.sync_s[4];
  assign src_sel = posref_pkg::src_t'(s_reg.src[1:0]);
  assign clr_mode = posref_pkg::clrm_t'(s_reg.clrm[2:0]);

  ////////////////////////////////////////////////////////////////////////
  // the two reference sources
  pulse_decoder dec_i (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .form_i(posref_pkg::form_t'(s_reg.act_form)),
    .line_a_i(a_s),
    .line_b_i(b_s),
    .unit_o(dec_u)
  );

  step_gen #(.PERIOD_CYC(STEP_PERIOD_CYC)) stp_i (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(src_sel == posref_pkg::SRC_STEP),
    .trig_i(trig_s),
    .amount_i(s_reg.step),
    .busy_o(stp_busy),
    .unit_o(stp_u)
  );

  ////////////////////////////////////////////////////////////////////////
  // source choice, error counter and clear, register port
  always_comb begin
    s_next = s_reg;
    s_next.sync_m = {error_clear_input_i, position_direction_select_i,
                     step_trigger_i, sign_input_i, command_pulse_input_i};
    s_next.sync_s = s_reg.sync_m;
    s_next.clr_q = clr_s;
    wval = wr_data_i[15:0];

    // multi-segment and comm sources feed nothing here
    case (src_sel)
      posref_pkg::SRC_PULSE: begin
        sel_pulse = dec_u.pulse;
        sel_dir = dec_u.dir;
      end
      posref_pkg::SRC_STEP: begin
        sel_pulse = stp_u.pulse;
        sel_dir = stp_u.dir;
      end
      default: begin
        sel_pulse = 1'b0;
        sel_dir = 1'b0;
      end
    endcase
    s_next.ref_pulse = sel_pulse;
    s_next.ref_dir = sel_dir ^ dsel_s;

    // stepping speed follows the direction input, not the amount sign
    s_next.busy = stp_busy;
    if (stp_busy) begin
      s_next.speed = dsel_s ? -posref_pkg::STEP_SPEED : posref_pkg::STEP_SPEED;
    end else begin
      s_next.speed = 16'sh0000;
    end

    // clear condition per mode; mode 1 is the one to use with no clear wire
    case (clr_mode)
      posref_pkg::CLR_FAULT_OFF: do_clear = fault_i;
      posref_pkg::CLR_FAULT: do_clear = fault_i;
      posref_pkg::CLR_LEVEL_HI: do_clear = clr_s;
      posref_pkg::CLR_LEVEL_LO: do_clear = !clr_s;
      posref_pkg::CLR_RISE: do_clear = clr_s && !s_reg.clr_q;
      posref_pkg::CLR_FALL: do_clear = !clr_s && s_reg.clr_q;
      default: do_clear = 1'b0;
    endcase

    // reference adds, feedback removes; clear beats counting
    delta = 32'sh0;
    if (s_reg.ref_pulse) begin
      delta = s_reg.ref_dir ? -32'sh1 : 32'sh1;
    end
    if (fb_pulse_i) begin
      delta = delta - (fb_dir_i ? -32'sh1 : 32'sh1);
    end
    s_next.err = do_clear ? 32'sh0 : s_reg.err + delta;

    // restart or reset loads the form; at any other time the form register waits
    s_next.load_form = 1'b0;
    if (s_reg.load_form) begin
      s_next.act_form = s_reg.form[1:0];
    end

    // register writes
    if (wr_en_i) begin
      case (addr_i)
        posref_pkg::SRC_OFS: s_next.src = wr_data_i[15:0];
        posref_pkg::STEP_OFS: begin
          // out-of-range amounts saturate to the limit
          if (wval > posref_pkg::STEP_MAX) begin
            s_next.step = posref_pkg::STEP_MAX;
          end else if (wval < posref_pkg::STEP_MIN) begin
            s_next.step = posref_pkg::STEP_MIN;
          end else begin
            s_next.step = wval;
          end
        end
        posref_pkg::FORM_OFS: s_next.form = wr_data_i[15:0];
        posref_pkg::CLRM_OFS: s_next.clrm = wr_data_i[15:0];
        posref_pkg::CTRL_OFS: begin
          s_next.load_form = wr_data_i[posref_pkg::CTRL_RESTART_BIT];
          if (wr_data_i[posref_pkg::CTRL_SERVO_ON_BIT]) begin
            s_next.servo_off = 1'b0;
          end
        end
        default: s_next.src = s_reg.src;
      endcase
    end

    // in mode 0, a fault in the same cycle as a servo-on write keeps the servo off
    if (fault_i && clr_mode == posref_pkg::CLR_FAULT_OFF) begin
      s_next.servo_off = 1'b1;
    end

    // read data stands for one cycle only
    s_next.rdata = 32'h0000_0000;
    if (rd_en_i) begin
      case (addr_i)
        posref_pkg::SRC_OFS: s_next.rdata = {16'h0000, s_reg.src};
        posref_pkg::STEP_OFS: s_next.rdata = {16'h0000, s_reg.step};
        posref_pkg::FORM_OFS: s_next.rdata = {16'h0000, s_reg.form};
        posref_pkg::CLRM_OFS: s_next.rdata = {16'h0000, s_reg.clrm};
        posref_pkg::STAT_OFS: begin
          s_next.rdata[posref_pkg::STAT_BUSY_BIT] = s_reg.busy;
          s_next.rdata[posref_pkg::STAT_SERVO_OFF_BIT] = s_reg.servo_off;
          s_next.rdata[posref_pkg::STAT_FORM_LSB +: 2] = s_reg.act_form;
        end
        posref_pkg::ERR_OFS: s_next.rdata = s_reg.err;
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; the form load is armed by reset itself
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
      s_reg.src <= posref_pkg::SRC_RST;
      s_reg.step <= posref_pkg::STEP_RST;
      s_reg.form <= posref_pkg::FORM_RST;
      s_reg.clrm <= posref_pkg::CLRM_RST;
      s_reg.load_form <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data_o = s_reg.rdata;
  assign ref_pulse_o = s_reg.ref_pulse;
  assign ref_dir_o = s_reg.ref_dir;
  assign speed_rpm_o = s_reg.speed;
  assign step_busy_o = s_reg.busy;
  assign servo_off_o = s_reg.servo_off;
  assign err_count_o = s_reg.err;

  ////////////////////////////////////////////////////////////////////////
  src_gate_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_reg.src[1] ##1 s_reg.src[1] |-> !s_reg.ref_pulse)
    else $error("reference from an inactive source");

  dir_rev_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    src_sel == posref_pkg::SRC_PULSE && dec_u.pulse
    |=> s_reg.ref_pulse && s_reg.ref_dir == ($past(dec_u.dir) ^ $past(dsel_s)))
    else $error("reference direction wrong");

  step_speed_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    stp_busy |=> s_reg.speed == ($past(dsel_s) ? -16'sh0018 : 16'sh0018))
    else $error("stepping speed wrong");

  fault_off_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clr_mode == posref_pkg::CLR_FAULT_OFF && fault_i |=> s_reg.servo_off && s_reg.err == 0)
    else $error("fault did not stop and clear");

  fault_keep_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clr_mode == posref_pkg::CLR_FAULT && fault_i && !s_reg.servo_off
    |=> !s_reg.servo_off && s_reg.err == 0)
    else $error("mode 1 fault handling wrong");

  clr_level_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clr_mode == posref_pkg::CLR_LEVEL_LO && !clr_s |=> s_reg.err == 0)
    else $error("level clear missed");

  clr_edge_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clr_mode == posref_pkg::CLR_FALL && $fell(clr_s) |=> s_reg.err == 0)
    else $error("edge clear missed");

  form_hold_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !s_reg.load_form |=> s_reg.act_form == $past(s_reg.act_form))
    else $error("pulse form changed without restart");

endmodule

// ---- testbench/host_model.sv ----
/*
  behavioural motion controller: drives the two command pulse lines, the
  step trigger, the direction select and the clear input of the drive.
  assumes the bench calls its tasks one at a time from one process.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  output logic line_a_o,
  output logic line_b_o,
  output logic trig_o,
  output logic dsel_o,
  output logic clr_o
);
  ////////////////////////////////////////////////////////////////////////
  // all pins idle low; no edge reaches the drive until a task asks for one
  initial begin
    line_a_o = 1'b0;
    line_b_o = 1'b0;
    trig_o = 1'b0;
    dsel_o = 1'b0;
    clr_o = 1'b0;
  end

  // three cycles per level keeps every pin above the two-cycle minimum
  task automatic hold();
    repeat (3) @(posedge clk_i);
  endtask

  // n full pulses on line a (forward pulse / cw line)
  task automatic pulse_a(input int n);
    repeat (2 * n) begin
      line_a_o <= ~line_a_o;
      hold();
    end
  endtask

  // n full pulses on line b (sign / ccw line)
  task automatic pulse_b(input int n);
    repeat (2 * n) begin
      line_b_o <= ~line_b_o;
      hold();
    end
  endtask

  // n half cycles of quadrature: two edges each, a ahead of b when fwd
  task automatic quad(input int n, input logic fwd);
    repeat (n) begin
      if (fwd) begin
        line_a_o <= ~line_a_o;
        hold();
        line_b_o <= ~line_b_o;
      end else begin
        line_b_o <= ~line_b_o;
        hold();
        line_a_o <= ~line_a_o;
      end
      hold();
    end
  endtask

  // one trigger pulse; the level drops again so a later rise is fresh
  task automatic trig_pulse();
    trig_o <= 1'b1;
    hold();
    trig_o <= 1'b0;
    hold();
  endtask

  // static levels: sign line, direction select and clear input
  task automatic set_levels(input logic b, input logic d, input logic c);
    line_b_o <= b;
    dsel_o <= d;
    clr_o <= c;
    hold();
  endtask
endmodule

// ---- testbench/tb_top.sv ----
/*
  self-checking bench of the position reference front end: register access,
  pulse forms, stepping moves and the six error clear modes.
  assumes the design is built with a short step period of 4 cycles.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk_i;
  logic sys_rst_i;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i;
  logic wr_en_i;
  logic rd_en_i;
  logic [31:0] rd_data_o;
  logic fault_i;
  logic fb_pulse_i;
  logic fb_dir_i;
  logic ref_pulse_o;
  logic ref_dir_o;
  logic signed [15:0] speed_rpm_o;
  logic step_busy_o;
  logic servo_off_o;
  logic signed [31:0] err_count_o;
  logic line_a;
  logic line_b;
  logic trig;
  logic dsel;
  logic clr;
  logic [31:0] d;
  int fail_count = 0;
  int compares = 0;
  int fwd_n = 0; // forward reference units seen
  int rev_n = 0; // reverse reference units seen

  ////////////////////////////////////////////////////////////////////////
  // short step period keeps moves to a few dozen cycles
  position_reference_frontend #(.STEP_PERIOD_CYC(4)) position_reference_frontend_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .command_pulse_input_i(line_a), .sign_input_i(line_b), .step_trigger_i(trig),
    .position_direction_select_i(dsel), .error_clear_input_i(clr), .fault_i(fault_i),
    .fb_pulse_i(fb_pulse_i), .fb_dir_i(fb_dir_i), .ref_pulse_o(ref_pulse_o),
    .ref_dir_o(ref_dir_o), .speed_rpm_o(speed_rpm_o), .step_busy_o(step_busy_o),
    .servo_off_o(servo_off_o), .err_count_o(err_count_o));

  host_model host_model_inst (.clk_i(clk_i), .line_a_o(line_a), .line_b_o(line_b),
    .trig_o(trig), .dsel_o(dsel), .clr_o(clr));

  ////////////////////////////////////////////////////////////////////////
  // clock at 50 MHz
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // unit counter; direction decides which count moves
  always @(posedge clk_i) begin
    if (ref_pulse_o === 1'b1) begin
      if (ref_dir_o) rev_n++;
      else fwd_n++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // wait n edges, then settle to the falling edge for sampling
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    @(negedge clk_i);
    v = rd_data_o;
  endtask

  // compare unit counts after the pipeline drains, then restart counting
  task automatic units(input int f, input int r);
    idle(8);
    chk(fwd_n, f);
    chk(rev_n, r);
    fwd_n = 0;
    rev_n = 0;
  endtask

  task automatic wait_busy(input logic v);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk_i);
      if (step_busy_o === v) return;
    end
    chk(step_busy_o, v);
  endtask

  // one-cycle drive error
  task automatic fault_pulse();
    @(posedge clk_i);
    fault_i <= 1'b1;
    @(posedge clk_i);
    fault_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    #(20 * 20000);
    fail_count++;
    report_and_stop();
  end

  initial begin
    sys_rst_i = 1'b1;
    addr_i = 8'h00;
    wr_data_i = 32'h0000_0000;
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    fault_i = 1'b0;
    fb_pulse_i = 1'b0;
    fb_dir_i = 1'b0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values and the register port
    rd(posref_pkg::SRC_OFS, d); chk(d, 32'h0000_0000);
    rd(posref_pkg::STEP_OFS, d); chk(d, 32'h0000_0032);
    rd(posref_pkg::FORM_OFS, d); chk(d, 32'h0000_0000);
    rd(posref_pkg::CLRM_OFS, d); chk(d, 32'h0000_0000);
    wr(8'h1C, 32'h0000_FFFF);
    rd(8'h1C, d); chk(d, 32'h0000_0000);
    // step amount saturates at both ends of its range
    wr(posref_pkg::STEP_OFS, 32'h0000_2710);
    rd(posref_pkg::STEP_OFS, d); chk(d, 32'h0000_270F);
    wr(posref_pkg::STEP_OFS, 32'h0000_D8F0);
    rd(posref_pkg::STEP_OFS, d); chk(d, 32'h0000_D8F1);
    // form 0: sign high forward, sign low reverse, select input flips it
    host_model_inst.set_levels(1'b1, 1'b0, 1'b0);
    host_model_inst.pulse_a(3); units(3, 0);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b0);
    host_model_inst.pulse_a(2); units(0, 2);
    host_model_inst.set_levels(1'b1, 1'b1, 1'b0);
    host_model_inst.pulse_a(2); units(0, 2);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b0);
    // new form waits for a restart
    wr(posref_pkg::FORM_OFS, 32'h0000_0002);
    rd(posref_pkg::STAT_OFS, d); chk({30'h0, d[3:2]}, 32'h0000_0000);
    wr(posref_pkg::CTRL_OFS, 32'h0000_0001);
    rd(posref_pkg::STAT_OFS, d); chk({30'h0, d[3:2]}, 32'h0000_0002);
    // quadrature: every edge is a unit, phase order gives direction
    host_model_inst.quad(2, 1'b1); units(4, 0);
    host_model_inst.quad(4, 1'b0); units(0, 8);
    // cw line forward, ccw line reverse
    wr(posref_pkg::FORM_OFS, 32'h0000_0003);
    wr(posref_pkg::CTRL_OFS, 32'h0000_0001);
    host_model_inst.pulse_a(2);
    host_model_inst.pulse_b(1); units(2, 1);
    // negative logic: falling edge counts, sign low forward
    wr(posref_pkg::FORM_OFS, 32'h0000_0001);
    wr(posref_pkg::CTRL_OFS, 32'h0000_0001);
    host_model_inst.pulse_a(2); units(2, 0);
    // stepping without trigger gives nothing; pulses are not routed
    wr(posref_pkg::SRC_OFS, 32'h0000_0002);
    host_model_inst.pulse_a(1); units(0, 0);
    wr(posref_pkg::SRC_OFS, 32'h0000_0001);
    host_model_inst.pulse_a(1); units(0, 0);
    wr(posref_pkg::STEP_OFS, 32'h0000_0003);
    host_model_inst.trig_pulse();
    wait_busy(1'b1);
    chk(speed_rpm_o, 32'h0000_0018);
    host_model_inst.trig_pulse();
    wait_busy(1'b0); units(3, 0);
    chk(speed_rpm_o, 32'h0000_0000);
    // reversed direction select turns the move and its speed round
    host_model_inst.set_levels(1'b0, 1'b1, 1'b0);
    wr(posref_pkg::STEP_OFS, 32'h0000_0002);
    host_model_inst.trig_pulse();
    wait_busy(1'b1);
    chk({{16{speed_rpm_o[15]}}, speed_rpm_o}, 32'hFFFF_FFE8);
    wait_busy(1'b0); units(0, 2);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b0);
    wr(posref_pkg::SRC_OFS, 32'h0000_0000);
    // mode 0: fault clears the error and switches the servo off
    fault_pulse(); idle(3);
    chk(err_count_o, 32'h0000_0000);
    chk(servo_off_o, 1'b1);
    wr(posref_pkg::CTRL_OFS, 32'h0000_0002); idle(2);
    chk(servo_off_o, 1'b0);
    // mode 1 with the clear input left idle
    wr(posref_pkg::CLRM_OFS, 32'h0000_0001);
    host_model_inst.pulse_a(2); idle(6);
    chk(err_count_o, 32'h0000_0002);
    fault_pulse(); idle(3);
    chk(err_count_o, 32'h0000_0000);
    chk(servo_off_o, 1'b0);
    // modes 2 and 3: level driven clearing
    host_model_inst.set_levels(1'b0, 1'b0, 1'b1);
    wr(posref_pkg::CLRM_OFS, 32'h0000_0002);
    host_model_inst.pulse_a(2); idle(6);
    chk(err_count_o, 32'h0000_0000);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b0);
    host_model_inst.pulse_a(2); idle(6);
    chk(err_count_o, 32'h0000_0002);
    wr(posref_pkg::CLRM_OFS, 32'h0000_0003); idle(3);
    chk(err_count_o, 32'h0000_0000);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b1);
    host_model_inst.pulse_a(1); idle(6);
    chk(err_count_o, 32'h0000_0001);
    // modes 4 and 5: edge driven clearing
    wr(posref_pkg::CLRM_OFS, 32'h0000_0004);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b0); idle(4);
    chk(err_count_o, 32'h0000_0001);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b1); idle(4);
    chk(err_count_o, 32'h0000_0000);
    wr(posref_pkg::CLRM_OFS, 32'h0000_0005);
    host_model_inst.pulse_a(2);
    @(posedge clk_i);
    fb_pulse_i <= 1'b1;
    fb_dir_i <= 1'b1;
    @(posedge clk_i);
    fb_dir_i <= 1'b0;
    @(posedge clk_i);
    fb_pulse_i <= 1'b0;
    idle(6);
    chk(err_count_o, 32'h0000_0002);
    host_model_inst.set_levels(1'b0, 1'b0, 1'b0); idle(4);
    chk(err_count_o, 32'h0000_0000);
    report_and_stop();
  end
endmodule
